// *** common/dcr_defines.svh ***
`ifndef DCR_DEFINES_SVH
`define DCR_DEFINES_SVH

// ----------------------------------------
// register offsets
// ----------------------------------------
`define DCR_ADDR_RX_VALID 16'h7615
`define DCR_ADDR_RX_ERROR 16'h761d
`define DCR_ADDR_TX_COUNT 16'h7625
`define DCR_ADDR_COMBINED 16'h9d3d
`define DCR_ADDR_CH1_CFG 16'h9d3e
`define DCR_ADDR_DIM_LEVEL 16'h9d4a

// ----------------------------------------
// bit positions
// ----------------------------------------
`define DCR_BIT_ON 0
`define DCR_BIT_SCENE 1
`define DCR_BIT_OFF 2
`define DCR_BIT_OVR1 3
`define DCR_BIT_PRES_EN 3
`define DCR_BIT_CH2_ON 4
`define DCR_BIT_DIM_DIS 4
`define DCR_BIT_CH2_SCENE 5
`define DCR_BIT_CH2_OFF 6
`define DCR_BIT_OVR2 7

// ----------------------------------------
// reset values and limits
// ----------------------------------------
`define DCR_RST_PRES_EN 1'b1
`define DCR_RST_DIM_LEVEL 8'h00
`define DCR_DIM_MAX 8'hfe
`define DCR_BCAST_ADDR 8'hff
`endif

// *** common/dcr_pkg.sv ***
package dcr_pkg;
    typedef enum logic [2:0] {
        DCR_CMD_OFF = 3'b001,
        DCR_CMD_SCENE = 3'b010,
        DCR_CMD_LEVEL = 3'b100
    } dcr_cmd_e;
    typedef logic [15:0] dcr_addr_t;
endpackage : dcr_pkg

// *** hdl/dcr_bank.sv ***
`timescale 1ns/1ps
`include "dcr_defines.svh"
module dcr_bank
    import dcr_pkg::*;
#(
    parameter int CNT_W = 32
) (
    // clock and reset
    input wire logic clk,
    input wire logic rst,
    // register port
    input wire logic [15:0] reg_addr,
    input wire logic [15:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [31:0] reg_rdata,
    // frame events from the channel-1 codec
    input wire logic ch1_rx_valid,
    input wire logic ch1_rx_error,
    input wire logic ch1_tx_done,
    // lighting state reported by the codecs
    input wire logic ch1_state_set,
    input wire logic ch1_state_clr,
    input wire logic ch2_state_set,
    input wire logic ch2_state_clr,
    // switch activity on input one
    input wire logic switch_input_one_press,
    input wire logic switch_input_one_hold,
    // broadcast commands, one-cycle pulses
    output logic ch1_cmd_valid,
    output logic [2:0] ch1_cmd,
    output logic [7:0] ch1_cmd_addr,
    output logic [7:0] ch1_cmd_level,
    output logic ch2_cmd_valid,
    output logic [2:0] ch2_cmd,
    output logic [7:0] ch2_cmd_addr,
    // control outputs
    output logic switch_input_one,
    output logic switch_input_two,
    output logic presence_one_enable,
    output logic input_one_dim_disable,
    output logic ch1_dim_step
);
    if (CNT_W != 32) begin : g_cnt_w_check
        $error("dcr_bank: counters must be 32 bits");
    end

    // ----------------------------------------
    // decode
    // ----------------------------------------
    logic wr_comb, wr_cfg, wr_dim;
    assign wr_comb = reg_wr && (reg_addr == `DCR_ADDR_COMBINED);
    assign wr_cfg = reg_wr && (reg_addr == `DCR_ADDR_CH1_CFG);
    assign wr_dim = reg_wr && (reg_addr == `DCR_ADDR_DIM_LEVEL);

    // ----------------------------------------
    // stored bits
    // ----------------------------------------
    logic ch1_on_q, ch2_on_q;
    logic scene1_q, off1_q, scene2_q, off2_q;
    logic ovr1_q, ovr2_q, pres_q, dimdis_q;
    logic [7:0] level_q;
    logic ch1_toggle;

    // shared ch1 bits: both registers write the same flops
    logic ch1_wr_on, ch1_wr_val;
    assign ch1_wr_on = wr_comb || wr_cfg;
    assign ch1_wr_val = reg_wdata[`DCR_BIT_ON];
    // switch toggles lighting even with dimming disabled
    // a press landing on a ch1 or level write is dropped: there is no queue
    assign ch1_toggle = switch_input_one && switch_input_one_press && !ch1_wr_on && !wr_dim;

    always_ff @(posedge clk) begin
        if (rst) begin
            ch1_on_q <= 1'b0;
        end else if (ch1_wr_on) begin
            ch1_on_q <= ch1_wr_val;
        end else if (ch1_toggle) begin
            ch1_on_q <= ~ch1_on_q;
        end else if (ch1_state_set) begin
            ch1_on_q <= 1'b1;
        end else if (ch1_state_clr) begin
            ch1_on_q <= 1'b0;
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            ch2_on_q <= 1'b0;
        end else if (wr_comb) begin
            ch2_on_q <= reg_wdata[`DCR_BIT_CH2_ON];
        end else if (ch2_state_set) begin
            ch2_on_q <= 1'b1;
        end else if (ch2_state_clr) begin
            ch2_on_q <= 1'b0;
        end
    end

    // edge bits remember last written value so a rise is detected once
    always_ff @(posedge clk) begin
        if (rst) begin
            scene1_q <= 1'b0;
            off1_q <= 1'b0;
        end else if (ch1_wr_on) begin
            scene1_q <= reg_wdata[`DCR_BIT_SCENE];
            off1_q <= reg_wdata[`DCR_BIT_OFF];
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            scene2_q <= 1'b0;
            off2_q <= 1'b0;
            ovr1_q <= 1'b0;
            ovr2_q <= 1'b0;
        end else if (wr_comb) begin
            scene2_q <= reg_wdata[`DCR_BIT_CH2_SCENE];
            off2_q <= reg_wdata[`DCR_BIT_CH2_OFF];
            ovr1_q <= reg_wdata[`DCR_BIT_OVR1];
            ovr2_q <= reg_wdata[`DCR_BIT_OVR2];
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            pres_q <= `DCR_RST_PRES_EN;
            dimdis_q <= 1'b0;
        end else if (wr_cfg) begin
            pres_q <= reg_wdata[`DCR_BIT_PRES_EN];
            dimdis_q <= reg_wdata[`DCR_BIT_DIM_DIS];
        end
    end

    // values above the maximum saturate at full brightness
    always_ff @(posedge clk) begin
        if (rst) begin
            level_q <= `DCR_RST_DIM_LEVEL;
        end else if (wr_dim) begin
            level_q <= (reg_wdata > 16'(`DCR_DIM_MAX)) ? `DCR_DIM_MAX : reg_wdata[7:0];
        end
    end

    // ----------------------------------------
    // command generation
    // ----------------------------------------
    logic c1_scene, c1_off, c2_scene, c2_off;
    always_comb begin
        c1_scene = 1'b0;
        c1_off = 1'b0;
        if (ch1_wr_on) begin
            c1_scene = (reg_wdata[`DCR_BIT_SCENE] && !scene1_q)
                || (ch1_wr_val && !ch1_on_q);
            c1_off = (reg_wdata[`DCR_BIT_OFF] && !off1_q)
                || (!ch1_wr_val && ch1_on_q);
        end
    end
    always_comb begin
        c2_scene = 1'b0;
        c2_off = 1'b0;
        if (wr_comb) begin
            c2_scene = (reg_wdata[`DCR_BIT_CH2_SCENE] && !scene2_q)
                || (reg_wdata[`DCR_BIT_CH2_ON] && !ch2_on_q);
            c2_off = (reg_wdata[`DCR_BIT_CH2_OFF] && !off2_q)
                || (!reg_wdata[`DCR_BIT_CH2_ON] && ch2_on_q);
        end
    end

    // off wins when a single write asks for both
    always_ff @(posedge clk) begin
        if (rst) begin
            ch1_cmd_valid <= 1'b0;
            ch1_cmd <= DCR_CMD_OFF;
            ch1_cmd_level <= 8'h00;
        end else begin
            ch1_cmd_valid <= c1_off || c1_scene || wr_dim || ch1_toggle;
            if (c1_off || (ch1_toggle && !ch1_wr_on && ch1_on_q)) begin
                ch1_cmd <= DCR_CMD_OFF;
            end else if (c1_scene || ch1_toggle) begin
                ch1_cmd <= DCR_CMD_SCENE;
            end else if (wr_dim) begin
                ch1_cmd <= DCR_CMD_LEVEL;
                ch1_cmd_level <= (reg_wdata > 16'(`DCR_DIM_MAX)) ? `DCR_DIM_MAX : reg_wdata[7:0];
            end
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            ch2_cmd_valid <= 1'b0;
            ch2_cmd <= DCR_CMD_OFF;
        end else begin
            ch2_cmd_valid <= c2_off || c2_scene;
            ch2_cmd <= c2_off ? DCR_CMD_OFF : DCR_CMD_SCENE;
        end
    end

    assign ch1_cmd_addr = `DCR_BCAST_ADDR;
    assign ch2_cmd_addr = `DCR_BCAST_ADDR;

    // ----------------------------------------
    // control outputs
    // ----------------------------------------
    assign switch_input_one = ovr1_q;
    assign switch_input_two = ovr2_q;
    assign presence_one_enable = pres_q;
    assign input_one_dim_disable = dimdis_q;
    assign ch1_dim_step = switch_input_one_hold && !dimdis_q;

    // ----------------------------------------
    // frame counters, wrap at full scale
    // ----------------------------------------
    logic [CNT_W-1:0] rxv_q, rxe_q, txc_q;
    always_ff @(posedge clk) begin
        if (rst) begin
            rxv_q <= '0;
        end else if (ch1_rx_valid) begin
            rxv_q <= rxv_q + 1'b1;
        end
    end
    always_ff @(posedge clk) begin
        if (rst) begin
            rxe_q <= '0;
        end else if (ch1_rx_error) begin
            rxe_q <= rxe_q + 1'b1;
        end
    end
    always_ff @(posedge clk) begin
        if (rst) begin
            txc_q <= '0;
        end else if (ch1_tx_done) begin
            txc_q <= txc_q + 1'b1;
        end
    end

    // ----------------------------------------
    // read port
    // ----------------------------------------
    always_ff @(posedge clk) begin
        if (rst) begin
            reg_rdata <= 32'h0000_0000;
        end else if (reg_rd) begin
            unique case (reg_addr)
                `DCR_ADDR_RX_VALID: reg_rdata <= rxv_q;
                `DCR_ADDR_RX_ERROR: reg_rdata <= rxe_q;
                `DCR_ADDR_TX_COUNT: reg_rdata <= txc_q;
                `DCR_ADDR_COMBINED: reg_rdata <= {24'h000000, ovr2_q, off2_q, scene2_q, ch2_on_q,
                    ovr1_q, off1_q, scene1_q, ch1_on_q};
                `DCR_ADDR_CH1_CFG: reg_rdata <= {27'h0000000, dimdis_q, pres_q, off1_q, scene1_q, ch1_on_q};
                `DCR_ADDR_DIM_LEVEL: reg_rdata <= {24'h000000, level_q};
                default: reg_rdata <= 32'h0000_0000;
            endcase
        end else begin
            reg_rdata <= 32'h0000_0000;
        end
    end

    // ----------------------------------------
    // checks
    // ----------------------------------------
    a_scene_rise_once: assert property (@(posedge clk) disable iff (rst)
        (wr_comb && reg_wdata[`DCR_BIT_CH2_SCENE] && scene2_q && reg_wdata[`DCR_BIT_CH2_ON] == ch2_on_q
         && !(reg_wdata[`DCR_BIT_CH2_OFF] && !off2_q)) |=> !ch2_cmd_valid)
        else $error("repeated scene write sent a command");
    a_ch1_scene_cmd: assert property (@(posedge clk) disable iff (rst)
        (ch1_wr_on && reg_wdata[`DCR_BIT_SCENE] && !scene1_q) |=> ch1_cmd_valid)
        else $error("ch1 scene rise lost");
    a_ch1_off_cmd: assert property (@(posedge clk) disable iff (rst)
        (ch1_wr_on && reg_wdata[`DCR_BIT_OFF] && !off1_q) |=> (ch1_cmd_valid && ch1_cmd == DCR_CMD_OFF))
        else $error("ch1 off rise lost");
    a_ch2_off_cmd: assert property (@(posedge clk) disable iff (rst)
        (wr_comb && reg_wdata[`DCR_BIT_CH2_OFF] && !off2_q) |=> (ch2_cmd_valid && ch2_cmd == DCR_CMD_OFF))
        else $error("ch2 off rise lost");
    a_ch2_state_fall: assert property (@(posedge clk) disable iff (rst)
        (wr_comb && !reg_wdata[`DCR_BIT_CH2_ON] && ch2_on_q) |=> (ch2_cmd_valid && !ch2_on_q))
        else $error("ch2 state fall not sent");
    a_ch2_scene_cmd: assert property (@(posedge clk) disable iff (rst)
        (wr_comb && reg_wdata[`DCR_BIT_CH2_SCENE] && !scene2_q) |=> ch2_cmd_valid)
        else $error("ch2 scene rise lost");
    a_shared_state: assert property (@(posedge clk) disable iff (rst)
        wr_cfg |=> (ch1_on_q == $past(reg_wdata[`DCR_BIT_ON])))
        else $error("ch1 state not shared");
    a_level_bcast: assert property (@(posedge clk) disable iff (rst)
        (wr_dim && !c1_off && !c1_scene && !ch1_toggle) |=> (ch1_cmd_valid && ch1_cmd == DCR_CMD_LEVEL
        && ch1_cmd_level <= `DCR_DIM_MAX))
        else $error("level not broadcast");
    a_counter_step: assert property (@(posedge clk) disable iff (rst)
        ch1_rx_valid |=> (rxv_q == $past(rxv_q) + 32'h1))
        else $error("valid counter missed");
    a_tx_count_step: assert property (@(posedge clk) disable iff (rst)
        !ch1_tx_done |=> (txc_q == $past(txc_q)))
        else $error("tx counter moved");
    a_err_count_step: assert property (@(posedge clk) disable iff (rst)
        ch1_rx_error |=> (rxe_q == $past(rxe_q) + 32'h1))
        else $error("error counter missed");

    // ----------------------------------------
    // command sequences
    // ----------------------------------------
    sequence s_ch1_on_rise;
        ch1_wr_on && ch1_wr_val && !ch1_on_q && !(reg_wdata[`DCR_BIT_OFF] && !off1_q);
    endsequence
    sequence s_ch1_on_fall;
        ch1_wr_on && !ch1_wr_val && ch1_on_q;
    endsequence
    sequence s_ch1_quiet_wr;
        ch1_wr_on && !(reg_wdata[`DCR_BIT_SCENE] && !scene1_q) && !(reg_wdata[`DCR_BIT_OFF] && !off1_q)
            && (ch1_wr_val == ch1_on_q);
    endsequence
    sequence s_ch1_scene_out;
        ch1_cmd_valid && (ch1_cmd == DCR_CMD_SCENE);
    endsequence
    sequence s_ch1_off_out;
        ch1_cmd_valid && (ch1_cmd == DCR_CMD_OFF);
    endsequence
    sequence s_ch2_on_rise;
        wr_comb && reg_wdata[`DCR_BIT_CH2_ON] && !ch2_on_q && !(reg_wdata[`DCR_BIT_CH2_OFF] && !off2_q);
    endsequence
    sequence s_ch2_quiet_wr;
        wr_comb && !(reg_wdata[`DCR_BIT_CH2_SCENE] && !scene2_q) && !(reg_wdata[`DCR_BIT_CH2_OFF] && !off2_q)
            && (reg_wdata[`DCR_BIT_CH2_ON] == ch2_on_q);
    endsequence
    sequence s_ch2_scene_out;
        ch2_cmd_valid && (ch2_cmd == DCR_CMD_SCENE);
    endsequence

    // ----------------------------------------
    // state bit and edge bit checks
    // ----------------------------------------
    a_ch1_on_rise: assert property (@(posedge clk) disable iff (rst)
        s_ch1_on_rise |=> s_ch1_scene_out)
        else $error("ch1 state rise did not recall scene");
    a_ch1_on_fall: assert property (@(posedge clk) disable iff (rst)
        s_ch1_on_fall |=> s_ch1_off_out)
        else $error("ch1 state fall did not send off");
    a_ch1_quiet_write: assert property (@(posedge clk) disable iff (rst)
        s_ch1_quiet_wr |=> !ch1_cmd_valid)
        else $error("ch1 write without edge sent a command");
    a_ch1_scene_kind: assert property (@(posedge clk) disable iff (rst)
        (ch1_wr_on && reg_wdata[`DCR_BIT_SCENE] && !scene1_q && !c1_off) |=> s_ch1_scene_out)
        else $error("ch1 scene rise sent wrong command");
    a_ch2_on_rise: assert property (@(posedge clk) disable iff (rst)
        s_ch2_on_rise |=> s_ch2_scene_out)
        else $error("ch2 state rise did not recall scene");
    a_ch2_quiet_write: assert property (@(posedge clk) disable iff (rst)
        s_ch2_quiet_wr |=> !ch2_cmd_valid)
        else $error("ch2 write without edge sent a command");
    a_ch2_scene_kind: assert property (@(posedge clk) disable iff (rst)
        (wr_comb && reg_wdata[`DCR_BIT_CH2_SCENE] && !scene2_q && !c2_off) |=> s_ch2_scene_out)
        else $error("ch2 scene rise sent wrong command");

    // ----------------------------------------
    // switch, override, level and read checks
    // ----------------------------------------
    a_toggle_flip: assert property (@(posedge clk) disable iff (rst)
        ch1_toggle |=> (ch1_cmd_valid && (ch1_on_q != $past(ch1_on_q))))
        else $error("switch press did not toggle ch1");
    a_toggle_off: assert property (@(posedge clk) disable iff (rst)
        (ch1_toggle && ch1_on_q) |=> s_ch1_off_out)
        else $error("switch press on lit ch1 did not send off");
    a_override_follow: assert property (@(posedge clk) disable iff (rst)
        wr_comb |=> ((switch_input_one == $past(reg_wdata[`DCR_BIT_OVR1]))
        && (switch_input_two == $past(reg_wdata[`DCR_BIT_OVR2]))))
        else $error("override bits not applied");
    a_cfg_follow: assert property (@(posedge clk) disable iff (rst)
        wr_cfg |=> ((presence_one_enable == $past(reg_wdata[`DCR_BIT_PRES_EN]))
        && (input_one_dim_disable == $past(reg_wdata[`DCR_BIT_DIM_DIS]))))
        else $error("ch1 config bits not applied");
    a_level_store: assert property (@(posedge clk) disable iff (rst)
        (wr_dim && (reg_wdata <= 16'(`DCR_DIM_MAX))) |=> ((level_q == $past(reg_wdata[7:0]))
        && (ch1_cmd_level == $past(reg_wdata[7:0]))))
        else $error("level not stored as written");
    a_level_clip: assert property (@(posedge clk) disable iff (rst)
        (wr_dim && (reg_wdata > 16'(`DCR_DIM_MAX))) |=> ((level_q == `DCR_DIM_MAX)
        && (ch1_cmd_level == `DCR_DIM_MAX)))
        else $error("level above maximum not clipped");
    a_tx_count_up: assert property (@(posedge clk) disable iff (rst)
        ch1_tx_done |=> (txc_q == $past(txc_q) + 32'h1))
        else $error("tx counter missed");
    a_ro_write_ignored: assert property (@(posedge clk) disable iff (rst)
        (reg_wr && !ch1_rx_valid) |=> (rxv_q == $past(rxv_q)))
        else $error("write moved the valid counter");
    a_ch2_state_read: assert property (@(posedge clk) disable iff (rst)
        (reg_rd && (reg_addr == `DCR_ADDR_COMBINED)) |=> (reg_rdata[`DCR_BIT_CH2_ON] == $past(ch2_on_q)))
        else $error("ch2 state read wrong");
    a_shared_read: assert property (@(posedge clk) disable iff (rst)
        (reg_rd && (reg_addr == `DCR_ADDR_CH1_CFG)) |=> ((reg_rdata[0] == $past(ch1_on_q))
        && (reg_rdata[1] == $past(scene1_q)) && (reg_rdata[2] == $past(off1_q))))
        else $error("shared ch1 bits read wrong");
endmodule : dcr_bank

// *** sim/dcr_ballast_model.sv ***
`timescale 1ns/1ps
module dcr_ballast_model
    import dcr_pkg::*;
(
    // clock and reset
    input wire logic clk,
    input wire logic rst,
    // broadcast commands
    input wire logic ch1_cmd_valid,
    input wire logic [2:0] ch1_cmd,
    input wire logic [7:0] ch1_cmd_addr,
    input wire logic ch2_cmd_valid,
    input wire logic [2:0] ch2_cmd,
    input wire logic [7:0] ch2_cmd_addr,
    // codec reports
    output logic ch1_tx_done,
    output logic ch1_state_set,
    output logic ch1_state_clr,
    output logic ch2_state_set,
    output logic ch2_state_clr
);
    // ----
    // ballasts obey only broadcast frames
    // ----
    logic hit1;
    logic hit2;
    assign hit1 = ch1_cmd_valid && ch1_cmd_addr == 8'hff;
    assign hit2 = ch2_cmd_valid && ch2_cmd_addr == 8'hff;
    // level frames leave the reported state alone: a limitation of this model
    always_ff @(posedge clk) begin
        if (rst) begin
            ch1_tx_done <= 1'b0;
            ch1_state_set <= 1'b0;
            ch1_state_clr <= 1'b0;
            ch2_state_set <= 1'b0;
            ch2_state_clr <= 1'b0;
        end else begin
            ch1_tx_done <= ch1_cmd_valid;
            ch1_state_set <= hit1 && ch1_cmd == DCR_CMD_SCENE;
            ch1_state_clr <= hit1 && ch1_cmd == DCR_CMD_OFF;
            ch2_state_set <= hit2 && ch2_cmd == DCR_CMD_SCENE;
            ch2_state_clr <= hit2 && ch2_cmd == DCR_CMD_OFF;
        end
    end
endmodule : dcr_ballast_model

// *** sim/test_dcr_bank.sv ***
`timescale 1ns/1ps
`include "dcr_defines.svh"
module test_dcr_bank
    import dcr_pkg::*;
;
    typedef struct {
        dcr_addr_t a;
        logic [15:0] d;
        logic v1;
        logic [2:0] c1;
        logic [7:0] l1;
        logic v2;
        logic [2:0] c2;
    } dcr_row_s;
    logic clk, rst, reg_wr, reg_rd, rxv, rxe, txd, s1, c1, s2, c2, press, hold;
    logic [15:0] reg_addr, reg_wdata;
    logic [31:0] reg_rdata;
    logic v1, v2, sw1, sw2, pres, dimdis, step;
    logic [2:0] cmd1, cmd2;
    logic [7:0] adr1, adr2, lvl1;
    int num_errors = 0;
    int n_tests = 0;
    int ntx = 0;
    int k;
    // ----
    // ordinary cases
    // ----
    dcr_row_s rows[14] = '{
        '{`DCR_ADDR_COMBINED, 16'h0002, 1, 3'h2, 8'h00, 0, 3'h0},
        '{`DCR_ADDR_COMBINED, 16'h0003, 0, 3'h0, 8'h00, 0, 3'h0},
        '{`DCR_ADDR_COMBINED, 16'h0004, 1, 3'h1, 8'h00, 0, 3'h0},
        '{`DCR_ADDR_CH1_CFG, 16'h000a, 1, 3'h2, 8'h00, 0, 3'h0},
        '{`DCR_ADDR_CH1_CFG, 16'h0008, 1, 3'h1, 8'h00, 0, 3'h0},
        '{`DCR_ADDR_COMBINED, 16'h0020, 0, 3'h0, 8'h00, 1, 3'h2},
        '{`DCR_ADDR_COMBINED, 16'h0070, 0, 3'h0, 8'h00, 1, 3'h1},
        '{`DCR_ADDR_COMBINED, 16'h0010, 0, 3'h0, 8'h00, 1, 3'h2},
        '{`DCR_ADDR_COMBINED, 16'h0000, 0, 3'h0, 8'h00, 1, 3'h1},
        '{`DCR_ADDR_COMBINED, 16'h0001, 1, 3'h2, 8'h00, 0, 3'h0},
        '{`DCR_ADDR_COMBINED, 16'h0000, 1, 3'h1, 8'h00, 0, 3'h0},
        '{`DCR_ADDR_DIM_LEVEL, 16'h0080, 1, 3'h4, 8'h80, 0, 3'h0},
        '{`DCR_ADDR_DIM_LEVEL, 16'h00ff, 1, 3'h4, 8'hfe, 0, 3'h0},
        '{16'h1234, 16'hffff, 0, 3'h0, 8'h00, 0, 3'h0}
    };
    dcr_bank i_dut (.clk(clk), .rst(rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
        .reg_rd(reg_rd), .reg_rdata(reg_rdata), .ch1_rx_valid(rxv), .ch1_rx_error(rxe), .ch1_tx_done(txd),
        .ch1_state_set(s1), .ch1_state_clr(c1), .ch2_state_set(s2), .ch2_state_clr(c2),
        .switch_input_one_press(press), .switch_input_one_hold(hold), .ch1_cmd_valid(v1), .ch1_cmd(cmd1),
        .ch1_cmd_addr(adr1), .ch1_cmd_level(lvl1), .ch2_cmd_valid(v2), .ch2_cmd(cmd2), .ch2_cmd_addr(adr2),
        .switch_input_one(sw1), .switch_input_two(sw2), .presence_one_enable(pres),
        .input_one_dim_disable(dimdis), .ch1_dim_step(step));
    dcr_ballast_model i_ballast (.clk(clk), .rst(rst), .ch1_cmd_valid(v1), .ch1_cmd(cmd1),
        .ch1_cmd_addr(adr1), .ch2_cmd_valid(v2), .ch2_cmd(cmd2), .ch2_cmd_addr(adr2), .ch1_tx_done(txd),
        .ch1_state_set(s1), .ch1_state_clr(c1), .ch2_state_set(s2), .ch2_state_clr(c2));
    initial begin
        clk = 1'b0;
        forever #12.5 clk = ~clk;
    end
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp, input string what);
        n_tests++;
        if (seen !== exp) begin
            num_errors++;
            $display("[FAIL] %0t %s: got %h want %h", $time, what, seen, exp);
        end
    endtask : chk
    task automatic wr(input dcr_addr_t a, input logic [15:0] d);
        @(posedge clk);
        reg_wr <= 1'b1;
        reg_addr <= a;
        reg_wdata <= d;
        @(posedge clk);
        reg_wr <= 1'b0;
        #1;
    endtask : wr
    task automatic rd(input dcr_addr_t a, input logic [31:0] exp);
        @(posedge clk);
        reg_rd <= 1'b1;
        reg_addr <= a;
        @(posedge clk);
        reg_rd <= 1'b0;
        #1 chk(reg_rdata, exp, "read");
    endtask : rd
    task automatic report_and_stop();
        if (num_errors == 0 && n_tests > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask : report_and_stop
    // the whole run needs a little over a hundred cycles
    initial begin
        repeat (3000) @(posedge clk);
        num_errors++;
        report_and_stop();
    end
    initial begin
        {rst, reg_wr, reg_rd, rxv, rxe, press, hold} = 7'h7f & 7'h40;
        reg_addr = 16'h0000;
        reg_wdata = 16'h0000;
        repeat (4) @(posedge clk);
        rst <= 1'b0;
        rd(`DCR_ADDR_CH1_CFG, 32'h8);
        rd(`DCR_ADDR_DIM_LEVEL, 32'h0);
        rd(`DCR_ADDR_TX_COUNT, 32'h0);
        foreach (rows[i]) begin
            wr(rows[i].a, rows[i].d);
            chk(v1, rows[i].v1, "ch1 pulse");
            chk(v2, rows[i].v2, "ch2 pulse");
            if (rows[i].v1) begin
                ntx++;
                chk({lvl1, cmd1}, {rows[i].l1, rows[i].c1}, "ch1 cmd");
                chk(adr1, 8'hff, "ch1 addr");
            end
            if (rows[i].v2) begin
                chk({adr2, cmd2}, {8'hff, rows[i].c2}, "ch2 cmd");
            end
            repeat (2) @(posedge clk);
        end
        rd(`DCR_ADDR_DIM_LEVEL, 32'hfe);
        rd(`DCR_ADDR_TX_COUNT, ntx);
        // ----
        // overrides, shared state, dimming
        // ----
        wr(`DCR_ADDR_COMBINED, 16'h0088);
        chk({sw1, sw2}, 2'b11, "override");
        wr(`DCR_ADDR_COMBINED, 16'h0008);
        chk({sw1, sw2}, 2'b10, "override");
        wr(`DCR_ADDR_COMBINED, 16'h0000);
        chk(sw1, 1'b0, "override");
        wr(`DCR_ADDR_COMBINED, 16'h0019);
        repeat (2) @(posedge clk);
        rd(`DCR_ADDR_COMBINED, 32'h19);
        rd(`DCR_ADDR_CH1_CFG, 32'h09);
        wr(`DCR_ADDR_CH1_CFG, 16'h0019);
        chk(dimdis, 1'b1, "dim off");
        @(posedge clk);
        hold <= 1'b1;
        press <= 1'b1;
        @(posedge clk);
        press <= 1'b0;
        #1 chk(step, 1'b0, "step");
        k = 0;
        while (v1 !== 1'b1 && k < 4) begin
            @(posedge clk);
            #1 k++;
        end
        chk({v1, cmd1}, {1'b1, 3'h1}, "toggle");
        repeat (2) @(posedge clk);
        wr(`DCR_ADDR_CH1_CFG, 16'h0008);
        chk(step, 1'b1, "step");
        // ----
        // counters, refusals, second reset
        // ----
        @(posedge clk);
        hold <= 1'b0;
        rxv <= 1'b1;
        rxe <= 1'b1;
        repeat (2) @(posedge clk);
        rxe <= 1'b0;
        @(posedge clk);
        rxv <= 1'b0;
        rd(`DCR_ADDR_RX_VALID, 32'h3);
        rd(`DCR_ADDR_RX_ERROR, 32'h2);
        wr(`DCR_ADDR_RX_VALID, 16'h5555);
        rd(`DCR_ADDR_RX_VALID, 32'h3);
        rd(16'h1234, 32'h0);
        wr(`DCR_ADDR_CH1_CFG, 16'h0000);
        chk(pres, 1'b0, "presence");
        @(posedge clk);
        rst <= 1'b1;
        repeat (2) @(posedge clk);
        rst <= 1'b0;
        #1 chk({pres, dimdis, sw1, v1}, 4'b1000, "presence");
        rd(`DCR_ADDR_RX_VALID, 32'h0);
        report_and_stop();
    end
endmodule : test_dcr_bank
